// ==== sim/drvsel_checker.sv ====
// ----------------------------------------
// Port checker
// ----------------------------------------
module drvsel_checker #(
    parameter int NUM_INPUTS    = drvsel_pkg::NUM_INPUTS,
    parameter int FILTER_CYCLES = drvsel_pkg::FILTER_CYCLES
) (
    input wire logic                      sys_clk,
    input wire logic                      rst,
    input wire logic [NUM_INPUTS-1:0]     digital_inputs,
    input wire logic [NUM_INPUTS*8-1:0]   input_function_codes,
    input wire logic [1:0]                start_source_setting,
    input wire logic [1:0]                reference_source_setting,
    input wire logic                      keypad_start_key,
    input wire logic                      keypad_stop_key,
    input wire logic                      bus_run_command,
    input wire logic                      bus_reverse_command,
    input wire logic                      motor_standstill,
    input wire logic                      run_command,
    input wire logic                      reverse_select,
    input wire logic                      decel_stop,
    input wire logic [1:0]                active_start_source,
    input wire logic [1:0]                active_reference_source,
    input wire logic                      use_keypad_reference_frequency,
    input wire logic                      second_parameter_set,
    input wire logic                      three_wire_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic both;
    always_comb
    begin
        both = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            for (int j = 0; j < NUM_INPUTS; j++)
            begin
                both |= (input_function_codes[8*i +: 8] == drvsel_pkg::FN_PULSE_START)
                        && (input_function_codes[8*j +: 8] == drvsel_pkg::FN_STOP_ENABLE);
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    src_hold_a: assert property (!motor_standstill [*3] |=> $stable(active_start_source))
        else $error("start source changed while moving");
    ref_hold_a: assert property (!motor_standstill [*3] |=> $stable(active_reference_source))
        else $error("reference source changed while moving");
    keypad_ref_a: assert property ((active_reference_source == 2'h2) [*2] |-> use_keypad_reference_frequency)
        else $error("stored reference not selected");
    stop_decel_a: assert property ($fell(run_command) && !$past(rst) && !motor_standstill |-> ##[0:1] decel_stop)
        else $error("stop without deceleration");
    decel_hold_a: assert property (decel_stop && !motor_standstill && !run_command |=> decel_stop || run_command)
        else $error("deceleration ended early");
    set_stop_a: assert property ($rose(second_parameter_set) |-> $past(motor_standstill) && !$past(run_command))
        else $error("second set taken while moving");
    three_wire_a: assert property (both [*2] |-> three_wire_active)
        else $error("three wire mode not flagged");
    src_code_a: assert property (active_start_source != 2'h0)
        else $error("start source has no meaning");
endmodule

bind drvsel_top drvsel_checker #(.NUM_INPUTS(NUM_INPUTS), .FILTER_CYCLES(FILTER_CYCLES)) u_chk (
    .sys_clk, .rst, .digital_inputs, .input_function_codes, .start_source_setting,
    .reference_source_setting, .keypad_start_key, .keypad_stop_key, .bus_run_command,
    .bus_reverse_command, .motor_standstill, .run_command, .reverse_select, .decel_stop,
    .active_start_source, .active_reference_source, .use_keypad_reference_frequency,
    .second_parameter_set, .three_wire_active
);

// ==== sim/drvsel_switches.sv ====
// ----------------------------------------
// Switches and motor on the far side
// ----------------------------------------
module drvsel_switches (
    input  wire logic       sys_clk,
    input  wire logic [4:0] want,
    input  wire logic       run_command,
    output logic [4:0]      digital_inputs,
    output logic            motor_standstill
);
    timeunit 1ns;
    timeprecision 1ps;
    int spin = 0;
    initial digital_inputs = 5'h00;
    initial motor_standstill = 1'b1;
    always @(posedge sys_clk)
    begin
        digital_inputs <= #1 want;
    end
    always @(posedge sys_clk)
    begin
        spin = run_command ? 8 : ((spin > 0) ? spin - 1 : 0);
        motor_standstill <= #1 (spin == 0);
    end
endmodule

// ==== sim/test_drive_run_command_selector.sv ====
// ----------------------------------------
// Testbench
// ----------------------------------------
module test_drive_run_command_selector;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  want = 5'h00;
    logic [4:0]  digital_inputs;
    logic [39:0] input_function_codes = {8'h33, 8'h08, 8'h16, 8'h15, 8'h14};
    logic [1:0]  start_source_setting = 2'h1;
    logic [1:0]  reference_source_setting = 2'h2;
    logic        keypad_start_key = 1'b0;
    logic        keypad_stop_key = 1'b0;
    logic        bus_run_command = 1'b0;
    logic        bus_reverse_command = 1'b0;
    logic        motor_standstill;
    logic        run_command, reverse_select, decel_stop;
    logic [1:0]  active_start_source, active_reference_source;
    logic        use_keypad_reference_frequency, second_parameter_set, three_wire_active;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    drvsel_top #(.FILTER_CYCLES(4)) dut (
        .sys_clk, .rst, .digital_inputs, .input_function_codes, .start_source_setting,
        .reference_source_setting, .keypad_start_key, .keypad_stop_key, .bus_run_command,
        .bus_reverse_command, .motor_standstill, .run_command, .reverse_select, .decel_stop,
        .active_start_source, .active_reference_source, .use_keypad_reference_frequency,
        .second_parameter_set, .three_wire_active
    );
    drvsel_switches u_sw (.sys_clk, .want, .run_command, .digital_inputs, .motor_standstill);

    task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic step(input logic [4:0] w, input int n);
        want = w;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_start;
        step(5'h00, 12);
        chk("three_wire", 1, three_wire_active);
        step(5'h01, 12);
        chk("run", 0, run_command);
        step(5'h02, 12);
        step(5'h03, 2);
        step(5'h02, 12);
        chk("run", 0, run_command);
        step(5'h03, 12);
        chk("run", 1, run_command);
        step(5'h02, 12);
        chk("run", 1, run_command);
        step(5'h06, 12);
        chk("reverse", 1, reverse_select);
        step(5'h02, 12);
        chk("reverse", 0, reverse_select);
        step(5'h00, 11);
        chk("run", 0, run_command);
        chk("decel", 1, decel_stop);
        step(5'h00, 12);
        chk("decel", 0, decel_stop);
    endtask

    task automatic t_sources;
        for (int i = 0; i < 4; i++)
        begin
            start_source_setting = (i == 0) ? 2'h1 : 2'(i);
            reference_source_setting = 2'(i);
            step(5'h02, 4);
            chk("start_src", start_source_setting, active_start_source);
            chk("ref_src", 2'(i), active_reference_source);
            chk("keypad_ref", 2'(i == 2), use_keypad_reference_frequency);
        end
        step(5'h12, 12);
        chk("start_src", 1, active_start_source);
        chk("ref_src", 1, active_reference_source);
        input_function_codes[39:32] = 8'h1F;
        step(5'h12, 12);
        chk("start_src", 2, active_start_source);
        chk("ref_src", 0, active_reference_source);
        start_source_setting = 2'h1;
        reference_source_setting = 2'h2;
        input_function_codes[39:32] = 8'h00;
        step(5'h12, 12);
        chk("run", 0, run_command);
        input_function_codes[39:32] = 8'h33;
        step(5'h02, 12);
        chk("start_src", 1, active_start_source);
        chk("ref_src", 2, active_reference_source);
    endtask

    task automatic t_refuse;
        start_source_setting = 2'h2;
        step(5'h03, 12);
        chk("run", 0, run_command);
        start_source_setting = 2'h1;
        step(5'h02, 12);
        step(5'h03, 12);
        start_source_setting = 2'h3;
        step(5'h02, 12);
        chk("start_src", 1, active_start_source);
        step(5'h1A, 12);
        chk("run", 0, run_command);
        chk("set2", 0, second_parameter_set);
        step(5'h12, 24);
        chk("run", 0, run_command);
    endtask

    task automatic t_set;
        start_source_setting = 2'h1;
        step(5'h0A, 12);
        chk("set2", 1, second_parameter_set);
        step(5'h0B, 12);
        step(5'h0A, 12);
        step(5'h02, 10);
        chk("set2", 0, second_parameter_set);
        step(5'h0A, 12);
        chk("set2", 0, second_parameter_set);
        step(5'h00, 24);
    endtask

    task automatic t_remote;
        start_source_setting = 2'h2;
        step(5'h00, 4);
        chk("start_src", 2, active_start_source);
        keypad_start_key = 1'b1;
        step(5'h00, 4);
        chk("run", 1, run_command);
        keypad_start_key = 1'b0;
        keypad_stop_key = 1'b1;
        step(5'h00, 4);
        chk("run", 0, run_command);
        chk("decel", 1, decel_stop);
        keypad_stop_key = 1'b0;
        start_source_setting = 2'h3;
        step(5'h00, 16);
        chk("start_src", 3, active_start_source);
        bus_run_command = 1'b1;
        bus_reverse_command = 1'b1;
        step(5'h00, 4);
        chk("run", 1, run_command);
        chk("reverse", 1, reverse_select);
        bus_run_command = 1'b0;
        bus_reverse_command = 1'b0;
        step(5'h00, 16);
        chk("run", 0, run_command);
        chk("reverse", 0, reverse_select);
    endtask

    task automatic results;
        $display("checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            results;
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_start;
        t_sources;
        t_refuse;
        t_set;
        t_remote;
        results;
    end
endmodule

// ==== verilog/drvsel_filter.sv ====
module drvsel_filter #(
    parameter int FILTER_CYCLES = drvsel_pkg::FILTER_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic raw_in,
    output logic      level
);
    localparam int CW = $clog2(FILTER_CYCLES + 1);

    typedef struct packed {
        logic          sync1;
        logic          sync2;
        logic [CW-1:0] count;
        logic          level;
    } drvsel_filt_type;

    drvsel_filt_type state;
    drvsel_filt_type next_state;

    // ----------------------------------------
    // Synchroniser and stability counter.
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.sync1 = raw_in;
        next_state.sync2 = state.sync1;
        if (state.sync2 == state.level)
        begin
            next_state.count = '0;
        end
        else if (state.count == CW'(FILTER_CYCLES - 1))
        begin
            next_state.count = '0;
            next_state.level = state.sync2;
        end
        else
        begin
            next_state.count = state.count + CW'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign level = state.level;
endmodule

// ==== verilog/drvsel_pkg.sv ====
package drvsel_pkg;
    localparam int          NUM_INPUTS     = 5;
    localparam logic [7:0]  FN_FWD_RUN     = 8'h00;
    localparam logic [7:0]  FN_REV_RUN     = 8'h01;
    localparam logic [7:0]  FN_SECOND_SET  = 8'h08;
    localparam logic [7:0]  FN_PULSE_START = 8'h14;
    localparam logic [7:0]  FN_STOP_ENABLE = 8'h15;
    localparam logic [7:0]  FN_DIRECTION   = 8'h16;
    localparam logic [7:0]  FN_FORCE_KEYPAD = 8'h1F;
    localparam logic [7:0]  FN_FORCE_TERM  = 8'h33;
    localparam logic [1:0]  START_SRC_INPUTS = 2'h1;
    localparam logic [1:0]  START_SRC_KEYPAD = 2'h2;
    localparam logic [1:0]  START_SRC_BUS    = 2'h3;
    localparam logic [1:0]  REF_SRC_POT      = 2'h0;
    localparam logic [1:0]  REF_SRC_ANALOG   = 2'h1;
    localparam logic [1:0]  REF_SRC_STORED   = 2'h2;
    localparam logic [1:0]  REF_SRC_BUS      = 2'h3;
    localparam int          CLK_HZ         = 40000000;
    localparam int          FILTER_MS      = 10;
    localparam int          FILTER_CYCLES  = CLK_HZ / 1000 * FILTER_MS;
    typedef enum logic [1:0] {
        DRVSEL_STOPPED,
        DRVSEL_RUNNING,
        DRVSEL_STOPPING
    } drvsel_run_type;
endpackage

// ==== verilog/drvsel_top.sv ====
module drvsel_top #(
    parameter int NUM_INPUTS    = drvsel_pkg::NUM_INPUTS,
    parameter int FILTER_CYCLES = drvsel_pkg::FILTER_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [NUM_INPUTS-1:0] digital_inputs,
    input  wire logic [NUM_INPUTS*8-1:0] input_function_codes,
    input  wire logic [1:0]            start_source_setting,
    input  wire logic [1:0]            reference_source_setting,
    input  wire logic                  keypad_start_key,
    input  wire logic                  keypad_stop_key,
    input  wire logic                  bus_run_command,
    input  wire logic                  bus_reverse_command,
    input  wire logic                  motor_standstill,
    output logic                       run_command,
    output logic                       reverse_select,
    output logic                       decel_stop,
    output logic [1:0]                 active_start_source,
    output logic [1:0]                 active_reference_source,
    output logic                       use_keypad_reference_frequency,
    output logic                       second_parameter_set,
    output logic                       three_wire_active
);
    logic [NUM_INPUTS-1:0] filt;

    // ----------------------------------------
    // Per-input filtering.
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++)
        begin : g_in
            drvsel_filter #(
                .FILTER_CYCLES (FILTER_CYCLES)
            ) u_filt (
                .sys_clk (sys_clk),
                .rst     (rst),
                .raw_in  (digital_inputs[gi]),
                .level   (filt[gi])
            );
        end
    endgenerate

    typedef struct packed {
        drvsel_pkg::drvsel_run_type run;
        logic                       start_prev;
        logic                       kstart_prev;
        logic                       force_term_prev;
        logic [1:0]                 start_src;
        logic [1:0]                 ref_src;
        logic                       second_set;
        logic                       run_command;
        logic                       reverse_select;
        logic                       decel_stop;
        logic                       keypad_ref;
        logic                       three_wire;
    } drvsel_state_type;

    drvsel_state_type state;
    drvsel_state_type next_state;

    // ----------------------------------------
    // Function decoding.
    // ----------------------------------------
    logic has_start;
    logic has_stop;
    logic start_lvl;
    logic stop_lvl;
    logic dir_lvl;
    logic fwd_lvl;
    logic rev_lvl;
    logic set_lvl;
    logic term_lvl;
    logic keypad_lvl;

    always_comb
    begin
        has_start  = 1'b0;
        has_stop   = 1'b0;
        start_lvl  = 1'b0;
        stop_lvl   = 1'b0;
        dir_lvl    = 1'b0;
        fwd_lvl    = 1'b0;
        rev_lvl    = 1'b0;
        set_lvl    = 1'b0;
        term_lvl   = 1'b0;
        keypad_lvl = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            unique case (input_function_codes[i*8 +: 8])
                drvsel_pkg::FN_PULSE_START:
                begin
                    has_start = 1'b1;
                    start_lvl = start_lvl | filt[i];
                end
                drvsel_pkg::FN_STOP_ENABLE:
                begin
                    has_stop = 1'b1;
                    stop_lvl = stop_lvl | filt[i];
                end
                drvsel_pkg::FN_DIRECTION:   dir_lvl    = dir_lvl | filt[i];
                drvsel_pkg::FN_FWD_RUN:     fwd_lvl    = fwd_lvl | filt[i];
                drvsel_pkg::FN_REV_RUN:     rev_lvl    = rev_lvl | filt[i];
                drvsel_pkg::FN_SECOND_SET:  set_lvl    = set_lvl | filt[i];
                drvsel_pkg::FN_FORCE_TERM:  term_lvl   = term_lvl | filt[i];
                drvsel_pkg::FN_FORCE_KEYPAD: keypad_lvl = keypad_lvl | filt[i];
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Source selection and run control.
    // ----------------------------------------
    logic       three_wire;
    logic [1:0] want_start_src;
    logic [1:0] want_ref_src;
    logic       start_edge;
    logic       kstart_edge;
    logic       run_req;
    logic       rev_req;

    always_comb
    begin
        three_wire = has_start & has_stop;
        want_start_src = start_source_setting;
        want_ref_src   = reference_source_setting;
        if (keypad_lvl)
        begin
            want_start_src = drvsel_pkg::START_SRC_KEYPAD;
            want_ref_src   = drvsel_pkg::REF_SRC_POT;
        end
        if (term_lvl)
        begin
            want_start_src = drvsel_pkg::START_SRC_INPUTS;
            want_ref_src   = drvsel_pkg::REF_SRC_ANALOG;
        end

        start_edge  = start_lvl & ~state.start_prev;
        kstart_edge = keypad_start_key & ~state.kstart_prev;
        run_req = 1'b0;
        rev_req = state.reverse_select;

        next_state = state;
        next_state.start_prev      = start_lvl;
        next_state.kstart_prev     = keypad_start_key;
        next_state.force_term_prev = term_lvl;
        next_state.three_wire      = three_wire;

        if (motor_standstill && state.run != drvsel_pkg::DRVSEL_RUNNING)
        begin
            next_state.start_src = want_start_src;
            next_state.ref_src   = want_ref_src;
            if (set_lvl)
            begin
                next_state.second_set = 1'b1;
            end
        end
        if (!set_lvl)
        begin
            next_state.second_set = 1'b0;
        end

        unique case (state.start_src)
            drvsel_pkg::START_SRC_INPUTS:
            begin
                if (three_wire)
                begin
                    run_req = state.run_command | (start_edge & stop_lvl);
                    rev_req = dir_lvl;
                end
                else
                begin
                    run_req = fwd_lvl | rev_lvl;
                    rev_req = rev_lvl & ~fwd_lvl;
                end
            end
            drvsel_pkg::START_SRC_KEYPAD:
            begin
                run_req = (state.run_command | kstart_edge) & ~keypad_stop_key;
            end
            drvsel_pkg::START_SRC_BUS:
            begin
                run_req = bus_run_command;
                rev_req = bus_reverse_command;
            end
            default:
            begin
                run_req = 1'b0;
            end
        endcase

        // stop enable required, stop on loss
        if (three_wire && state.start_src == drvsel_pkg::START_SRC_INPUTS && !stop_lvl)
        begin
            run_req = 1'b0;
        end
        if (term_lvl != state.force_term_prev)
        begin
            run_req = 1'b0;
        end

        unique case (state.run)
            drvsel_pkg::DRVSEL_STOPPED:
            begin
                if (run_req)
                begin
                    next_state.run = drvsel_pkg::DRVSEL_RUNNING;
                end
            end
            drvsel_pkg::DRVSEL_RUNNING:
            begin
                if (!run_req)
                begin
                    next_state.run = drvsel_pkg::DRVSEL_STOPPING;
                end
            end
            drvsel_pkg::DRVSEL_STOPPING:
            begin
                if (motor_standstill)
                begin
                    next_state.run = drvsel_pkg::DRVSEL_STOPPED;
                end
            end
            default:
            begin
                next_state.run = drvsel_pkg::DRVSEL_STOPPED;
            end
        endcase

        next_state.run_command    = (next_state.run == drvsel_pkg::DRVSEL_RUNNING);
        next_state.decel_stop     = (next_state.run == drvsel_pkg::DRVSEL_STOPPING);
        next_state.reverse_select = rev_req;
        next_state.keypad_ref = (next_state.ref_src == drvsel_pkg::REF_SRC_STORED);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= '0;
            state.run <= drvsel_pkg::DRVSEL_STOPPED;
            state.start_src <= drvsel_pkg::START_SRC_INPUTS;
            state.ref_src <= drvsel_pkg::REF_SRC_POT;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign second_parameter_set           = state.second_set;
    assign run_command                    = state.run_command;
    assign reverse_select                 = state.reverse_select;
    assign decel_stop                     = state.decel_stop;
    assign active_start_source            = state.start_src;
    assign active_reference_source        = state.ref_src;
    assign use_keypad_reference_frequency = state.keypad_ref;
    assign three_wire_active              = state.three_wire;
endmodule
